// [rtl/aaops_top.sv]
// Add and AND execution slice with an AXI4-Lite register port.
// Assumes the file register memory sits outside and answers file_rdata
// combinationally for file_addr in the same cycle.
// ==========================================================
// Overview of operation
// - Add-immediate adds the byte to the accumulator; C, nibble carry, Z.
// - AND-immediate masks the accumulator with the byte; only Z changes.
// - Add-register sums accumulator and file register; C, nibble carry, Z.
// - AND-register masks accumulator with file register; only Z changes.
// - Target bit 0 puts the result in the accumulator only.
// - Target bit 1 writes the result back to the register only.
// - Register operand is a 7-bit address from the low instruction bits.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "aaops_consts.svh"
module aaops_top
#(
  parameter int ADDR_W = 4,
  parameter int FADDR_W = 7
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // File register memory port
  output logic [FADDR_W-1:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic [7:0] file_wdata,
  output logic file_we,
  // Execution state
  output logic busy
);
  import aaops_pkg::*;

  // ==========================================================
  // Decode
  // Upper opcode bits to operation
  function automatic aaops_op_t decode_op(input logic [13:0] iw);
    logic [5:0] opc;
    opc = iw[`AAOPS_OPC_HI:`AAOPS_OPC_LO];
    if (opc[5:1] == `AAOPS_OPC_ADD_IMM) begin
      decode_op = AAOPS_OP_ADD_IMM;
    end else if (opc == `AAOPS_OPC_AND_IMM) begin
      decode_op = AAOPS_OP_AND_IMM;
    end else if (opc == `AAOPS_OPC_ADD_REG) begin
      decode_op = AAOPS_OP_ADD_REG;
    end else if (opc == `AAOPS_OPC_AND_REG) begin
      decode_op = AAOPS_OP_AND_REG;
    end else begin
      decode_op = AAOPS_OP_NONE;
    end
  endfunction

  // Byte-lane merge of a write into a 32-bit image
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge_bytes = res;
  endfunction

  // ==========================================================
  // State
  aaops_state_t state_q, state_d;
  logic [13:0] instr_q, instr_d;
  logic [7:0] acc_q, acc_d;
  logic carry_q, carry_d;
  logic nibble_q, nibble_d;
  logic zero_q, zero_d;
  logic illegal_q, illegal_d;
  logic [7:0] wdata_q, wdata_d;
  logic we_q, we_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  aaops_op_t cur_op;
  logic is_reg_op;
  logic is_add;
  logic [7:0] opb;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic wr_go;
  logic rd_go;
  logic [31:0] status_img;
  logic [31:0] st_new, instr_new;

  // ==========================================================
  // Datapath
  // Operation and operand selection
  always_comb begin
    cur_op = decode_op(instr_q);
    is_reg_op = (cur_op == AAOPS_OP_ADD_REG) || (cur_op == AAOPS_OP_AND_REG);
    is_add = (cur_op == AAOPS_OP_ADD_IMM) || (cur_op == AAOPS_OP_ADD_REG);
    opb = is_reg_op ? file_rdata : instr_q[`AAOPS_IMM_HI:0];
  end

  aaops_alu #(
    .WIDTH(8)
  ) u_alu (
    .opa(acc_q),
    .opb(opb),
    .do_add(is_add),
    .result(alu_res),
    .carry_out(alu_c),
    .low_nibble_outflow(alu_dc),
    .zero(alu_z)
  );

  // Status word as software sees it
  always_comb begin
    status_img = 32'h0000_0000;
    status_img[`AAOPS_ST_CARRY] = carry_q;
    status_img[`AAOPS_ST_NIBBLE] = nibble_q;
    status_img[`AAOPS_ST_ZERO] = zero_q;
    status_img[`AAOPS_ST_ILLEGAL] = illegal_q;
  end

  // ==========================================================
  // Bus handshakes
  // Write taken with both channels present, response slot free and sequencer idle
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q &&
                 (state_q == AAOPS_ST_IDLE);
  assign rd_go = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // ==========================================================
  // Next-state logic
  always_comb begin
    state_d = state_q;
    instr_d = instr_q;
    acc_d = acc_q;
    carry_d = carry_q;
    nibble_d = nibble_q;
    zero_d = zero_q;
    illegal_d = illegal_q;
    wdata_d = wdata_q;
    we_d = 1'b0;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    st_new = merge_bytes(status_img, s_axi_wdata, s_axi_wstrb);
    instr_new = merge_bytes({18'h0, instr_q}, s_axi_wdata, s_axi_wstrb);

    // Register writes from the bus
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = `AAOPS_RESP_OKAY;
      case (s_axi_awaddr)
        `AAOPS_OFF_INSTR: begin
          instr_d = instr_new[13:0];
          state_d = AAOPS_ST_EXEC;
        end
        `AAOPS_OFF_ACC: begin
          if (s_axi_wstrb[0]) begin
            acc_d = s_axi_wdata[7:0];
          end
        end
        `AAOPS_OFF_STATUS: begin
          carry_d = st_new[`AAOPS_ST_CARRY];
          nibble_d = st_new[`AAOPS_ST_NIBBLE];
          zero_d = st_new[`AAOPS_ST_ZERO];
          illegal_d = st_new[`AAOPS_ST_ILLEGAL];
        end
        default: begin
          bresp_d = `AAOPS_RESP_SLVERR;
        end
      endcase
    end

    // Instruction sequencing
    case (state_q)
      AAOPS_ST_IDLE: begin
        state_d = wr_go ? state_d : AAOPS_ST_IDLE;
      end
      AAOPS_ST_EXEC: begin
        state_d = AAOPS_ST_IDLE;
        if (cur_op == AAOPS_OP_NONE) begin
          illegal_d = 1'b1;
        end else begin
          zero_d = alu_z;
          if (is_add) begin
            carry_d = alu_c;
            nibble_d = alu_dc;
          end
          if (is_reg_op && instr_q[`AAOPS_TGT_BIT]) begin
            wdata_d = alu_res;
            we_d = 1'b1;
            state_d = AAOPS_ST_WBACK;
          end else begin
            acc_d = alu_res;
          end
        end
      end
      AAOPS_ST_WBACK: begin
        state_d = AAOPS_ST_IDLE;
      end
      default: begin
        state_d = AAOPS_ST_IDLE;
      end
    endcase

    // Register reads
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = `AAOPS_RESP_OKAY;
      case (s_axi_araddr)
        `AAOPS_OFF_INSTR: rdata_d = {18'h0, instr_q};
        `AAOPS_OFF_ACC: rdata_d = {24'h0, acc_q};
        `AAOPS_OFF_STATUS: rdata_d = status_img;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `AAOPS_RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= AAOPS_ST_IDLE;
      instr_q <= `AAOPS_RST_INSTR;
      acc_q <= `AAOPS_RST_ACC;
      {illegal_q, zero_q, nibble_q, carry_q} <= `AAOPS_RST_FLAGS;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `AAOPS_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `AAOPS_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      instr_q <= instr_d;
      acc_q <= acc_d;
      carry_q <= carry_d;
      nibble_q <= nibble_d;
      zero_q <= zero_d;
      illegal_q <= illegal_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs
  // Register operand address from the low instruction bits
  assign file_addr = instr_q[`AAOPS_FADDR_HI:0];
  assign file_wdata = wdata_q;
  assign file_we = we_q;
  assign busy = (state_q != AAOPS_ST_IDLE);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
endmodule

// [rtl/aaops_consts.svh]
// Constants of the add and AND datapath slice: offsets, fields, resets.
// Assumes inclusion by bare name from the package and design modules.
`ifndef AAOPS_CONSTS_SVH
`define AAOPS_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define AAOPS_OFF_INSTR 4'h0
`define AAOPS_OFF_ACC 4'h4
`define AAOPS_OFF_STATUS 4'h8

// ==========================================================
// Instruction word fields
`define AAOPS_OPC_HI 13
`define AAOPS_OPC_LO 8
`define AAOPS_TGT_BIT 7
`define AAOPS_FADDR_HI 6
`define AAOPS_IMM_HI 7

// ==========================================================
// Upper opcode patterns
`define AAOPS_OPC_ADD_IMM 5'h1F
`define AAOPS_OPC_AND_IMM 6'h39
`define AAOPS_OPC_ADD_REG 6'h07
`define AAOPS_OPC_AND_REG 6'h05

// ==========================================================
// Status register bit positions
`define AAOPS_ST_CARRY 0
`define AAOPS_ST_NIBBLE 1
`define AAOPS_ST_ZERO 2
`define AAOPS_ST_ILLEGAL 3

// ==========================================================
// Reset values and bus responses
`define AAOPS_RST_INSTR 14'h0000
`define AAOPS_RST_ACC 8'h00
`define AAOPS_RST_FLAGS 4'h0
`define AAOPS_RESP_OKAY 2'h0
`define AAOPS_RESP_SLVERR 2'h2

`endif

// [rtl/aaops_pkg.sv]
// Types shared by the add and AND datapath slice.
// Assumes the constants header sits in the include path.
package aaops_pkg;
  `include "aaops_consts.svh"

  // Operation selected by the upper opcode bits
  typedef enum logic [2:0] {
    AAOPS_OP_NONE = 3'h0,
    AAOPS_OP_ADD_IMM = 3'h1,
    AAOPS_OP_AND_IMM = 3'h2,
    AAOPS_OP_ADD_REG = 3'h3,
    AAOPS_OP_AND_REG = 3'h4
  } aaops_op_t;

  // Sequencer states, Gray along idle, execute, write back
  typedef enum logic [1:0] {
    AAOPS_ST_IDLE = 2'h0,
    AAOPS_ST_EXEC = 2'h1,
    AAOPS_ST_WBACK = 2'h3
  } aaops_state_t;
endpackage

// [rtl/aaops_alu.sv]
// Eight-bit adder and AND unit with carry, nibble carry and zero outputs.
// Assumes operands are stable in the cycle the result is sampled.
`timescale 1ns/1ns
module aaops_alu #(
  parameter int WIDTH = 8
) (
  // Operands and operation
  input wire logic [WIDTH-1:0] opa,
  input wire logic [WIDTH-1:0] opb,
  input wire logic do_add,
  // Result and flags
  output logic [WIDTH-1:0] result,
  output logic carry_out,
  output logic low_nibble_outflow,
  output logic zero
);
  logic [WIDTH:0] sum;
  logic [4:0] low_sum;

  // Full sum and low nibble sum
  always_comb begin
    sum = {1'b0, opa} + {1'b0, opb};
    low_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
    result = do_add ? sum[WIDTH-1:0] : (opa & opb);
    carry_out = sum[WIDTH];
    low_nibble_outflow = low_sum[4];
    zero = (result == '0);
  end
endmodule

// [bench/aaops_top_props.sv]
// Checker of the add and AND slice, watching its top ports only.
// Assumes it is bound into every aaops_top instance.
`timescale 1ns/1ns
module aaops_top_props #(
  parameter int ADDR_W = 4,
  parameter int FADDR_W = 7
) (
  // Clock, reset and write request
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  // File port and state
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] file_wdata,
  input wire logic file_we,
  input wire logic busy
);
  logic [31:0] instr_q;
  // Last instruction word taken
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == '0) begin
      instr_q <= s_axi_wdata;
    end
  end
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Sequences
  sequence s_take;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == '0;
  endsequence
  sequence s_imm;
    s_take ##0 s_axi_wdata[13:12] == 2'h3;
  endsequence
  sequence s_reg;
    s_take ##0 (s_axi_wdata[13:8] == 6'h07 || s_axi_wdata[13:8] == 6'h05);
  endsequence
  sequence s_wback;
    busy ##1 (file_we && busy) ##1 (!file_we && !busy);
  endsequence
  // ==========================================================
  // Properties
  property p_busy;
    s_take |=> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("no execute");
  property p_imm_short;
    s_imm |=> busy ##1 !busy;
  endproperty
  a_imm_short: assert property (p_imm_short) else $error("no idle");
  property p_imm_nowb;
    s_imm |=> !file_we [*3];
  endproperty
  a_imm_nowb: assert property (p_imm_nowb) else $error("imm wrote");
  property p_addr;
    s_take |=> file_addr == instr_q[6:0];
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_acc_tgt;
    s_reg ##0 !s_axi_wdata[7] |=> !file_we [*3];
  endproperty
  a_acc_tgt: assert property (p_acc_tgt) else $error("file write");
  property p_wb_tgt;
    s_reg ##0 s_axi_wdata[7] |=> s_wback;
  endproperty
  a_wb_tgt: assert property (p_wb_tgt) else $error("no wback");
  property p_and_mask;
    file_we && instr_q[13:8] == 6'h05 |-> (file_wdata & ~file_rdata) == 8'h00;
  endproperty
  a_and_mask: assert property (p_and_mask) else $error("and bits");
  property p_we_addr;
    file_we |-> file_addr == instr_q[6:0] && $past(busy);
  endproperty
  a_we_addr: assert property (p_we_addr) else $error("we addr");
endmodule

bind aaops_top aaops_top_props #(.ADDR_W(ADDR_W), .FADDR_W(FADDR_W)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .file_addr(file_addr),
  .file_rdata(file_rdata), .file_wdata(file_wdata),
  .file_we(file_we), .busy(busy)
);

// [bench/test_add_and_alu_ops.sv]
// Self-checking bench of the add and AND slice over its register port.
// Assumes a behavioural file memory answering file_rdata at once.
`timescale 1ns/1ns
module test_add_and_alu_ops;
  typedef struct packed {
    logic [13:0] instr;
    logic [7:0] acc, st, mem, eacc, est, emem;
  } aaops_row_t;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, file_we, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [6:0] file_addr;
  logic [7:0] file_rdata, file_wdata;
  logic [7:0] mem [128];
  int n_errors = 0, num_checks = 0;
  // Instruction, acc, status, operand, expected acc, status, operand
  aaops_row_t rows [10] = '{
    '{14'h3E15, 8'h10, 8'h07, 8'h5A, 8'h25, 8'h00, 8'h5A},
    '{14'h3F01, 8'hFF, 8'h00, 8'h5A, 8'h00, 8'h07, 8'h5A},
    '{14'h3E08, 8'h08, 8'h00, 8'h5A, 8'h10, 8'h02, 8'h5A},
    '{14'h395F, 8'hA3, 8'h03, 8'h5A, 8'h03, 8'h03, 8'h5A},
    '{14'h395C, 8'hA3, 8'h03, 8'h5A, 8'h00, 8'h07, 8'h5A},
    '{14'h0725, 8'h17, 8'h00, 8'hC2, 8'hD9, 8'h00, 8'hC2},
    '{14'h07FF, 8'h17, 8'h00, 8'hC2, 8'h17, 8'h00, 8'hD9},
    '{14'h07A5, 8'h80, 8'h00, 8'h80, 8'h80, 8'h05, 8'h00},
    '{14'h0501, 8'h17, 8'h03, 8'hC2, 8'h02, 8'h03, 8'hC2},
    '{14'h05C0, 8'h17, 8'h04, 8'hC2, 8'h17, 8'h00, 8'h02}};

  // Clock and file memory
  always #10 aclk = ~aclk;
  assign file_rdata = mem[file_addr];
  always @(posedge aclk) begin
    if (file_we) begin
      mem[file_addr] <= file_wdata;
    end
  end

  aaops_top u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .file_addr, .file_rdata, .file_wdata,
    .file_we, .busy
  );

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  // Bounded wait, on settled values, for a handshake or idle
  task automatic wait_for(input int s);
    int i;
    i = 0;
    @(negedge aclk);
    while ((s == 0 ? s_axi_awready : s == 1 ? s_axi_bvalid :
            s == 2 ? s_axi_arready : s == 3 ? s_axi_rvalid :
            !busy) !== 1'h1) begin
      if (++i > 100) begin
        n_errors++;
        end_of_test();
      end
      @(negedge aclk);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    wait_for(0);
    @(posedge aclk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    wait_for(1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    wait_for(2);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    wait_for(3);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    for (int a = 0; a < 3; a++) begin
      axi_rd(4'(a * 4));
      chk("reset value", 32'h0, d);
    end
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      axi_wr(4'h4, {24'h0, rows[i].acc});
      axi_wr(4'h8, {24'h0, rows[i].st});
      mem[rows[i].instr[6:0]] = rows[i].mem;
      axi_wr(4'h0, {18'h0, rows[i].instr});
      wait_for(4);
      axi_rd(4'h4);
      chk("acc", {24'h0, rows[i].eacc}, d);
      axi_rd(4'h8);
      chk("status", {24'h0, rows[i].est}, d);
      chk("operand", {24'h0, rows[i].emem},
          {24'h0, mem[rows[i].instr[6:0]]});
      $display("row %0d done", i);
    end
    // Unknown opcode, then two adds back to back
    axi_wr(4'h4, 32'h55);
    axi_wr(4'h8, 32'h0);
    axi_wr(4'h0, 32'h3A00);
    axi_wr(4'h0, 32'h3E01);
    axi_wr(4'h0, 32'h3E01);
    wait_for(4);
    axi_rd(4'h4);
    chk("acc b2b", 32'h57, d);
    axi_rd(4'h8);
    chk("status b2b", 32'h8, d);
    $display("sequence test done");
    axi_wr(4'hC, 32'h1);
    chk("bresp", 32'h2, {30'h0, r});
    axi_rd(4'hC);
    chk("rresp", 32'h2, {30'h0, r});
    chk("rdata", 32'h0, d);
    $display("unmapped test done");
    // Partial strobes: ACC needs lane 0, INSTR merges lane by lane
    s_axi_wstrb <= 4'hE;
    axi_wr(4'h4, 32'h99);
    s_axi_wstrb <= 4'h1;
    axi_wr(4'h0, 32'hFF02);
    s_axi_wstrb <= 4'hF;
    wait_for(4);
    axi_rd(4'h4);
    chk("acc strobe", 32'h59, d);
    axi_rd(4'h0);
    chk("instr strobe", 32'h3E02, d);
    $display("strobe test done");
    end_of_test();
  end
endmodule
